// ---- src/epc_top.sv ----
// EPROM latch/program control with AXI4-Lite register and array access
//
// Contract
// - Clearing latch clears program; normal ROM reads
// - Latch set makes array reads invalid
// - Vector fetches invalid while latch set
// - Bootstrap ROM blocked while latch set
// - Stop entry forces read mode
// - Unprogrammed byte reads zero
// - Programming only adds one bits
// - Eight bytes share upper address bits
// - Array holds 15168 bytes, 14 vector bytes
// - Program set needs latch and byte
// - Software cannot clear program bit while latch stays set
// - Stop and resets clear latch
// - Latch captures address and eight bytes
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module epc_top
	import epc_pkg::*;
(
	input  wire logic              aclk,          // Clock, 40 MHz
	input  wire logic              aresetn,       // Synchronous reset, low
	input  wire logic              stop_entry,    // Pulse on stop-state entry
	input  wire logic [31:0]       s_awaddr,      // Write address
	input  wire logic              s_awvalid,     // Write address valid
	output logic                   s_awready,     // Write address ready
	input  wire logic [31:0]       s_wdata,       // Write data
	input  wire logic [3:0]        s_wstrb,       // Write strobes
	input  wire logic              s_wvalid,      // Write data valid
	output logic                   s_wready,      // Write data ready
	output logic [1:0]             s_bresp,       // Write response
	output logic                   s_bvalid,      // Write response valid
	input  wire logic              s_bready,      // Write response ready
	input  wire logic [31:0]       s_araddr,      // Read address
	input  wire logic              s_arvalid,     // Read address valid
	output logic                   s_arready,     // Read address ready
	output logic [31:0]            s_rdata,       // Read data
	output logic [1:0]             s_rresp,       // Read response
	output logic                   s_rvalid,      // Read data valid
	input  wire logic              s_rready,      // Read data ready
	output logic                   boot_blocked,  // Bootstrap ROM fetch disabled
	output logic                   vector_invalid,// Vector fetch not valid
	output logic                   prog_active    // Program enable, for supply switch
);
	import epc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State
	epc_ctrl_t              ctrl_ff, nxt_ctrl;
	logic [7:0]             mem_ff [MEM_BYTES];
	logic [7:0]             buf_ff [LANES];
	logic [LANES-1:0]       lane_ff, nxt_lane;
	logic [MEM_AW-4:0]      grp_ff, nxt_grp;
	logic                   aw_ff, nxt_aw, w_ff, nxt_w;
	logic [31:0]            awa_ff, nxt_awa, wd_ff, nxt_wd;
	logic [3:0]             ws_ff, nxt_ws;
	logic                   bv_ff, nxt_bv, rv_ff, nxt_rv;
	logic [1:0]             br_ff, nxt_br, rr_ff, nxt_rr;
	logic [31:0]            rd_ff, nxt_rd;
	logic                   arr_ff, nxt_arr;
	logic                   stat_ff;
	epc_mode_t              mode;

	logic        wr_go, wr_ctrl, wr_mem, rd_go;
	logic [31:0] mem_off, rmem_off;
	logic [MEM_AW-1:0] widx;

	assign mode     = ctrl_ff.pgm ? EPC_PROG : (ctrl_ff.lat ? EPC_LOAD : EPC_READ);
	assign wr_go    = aw_ff && w_ff && !bv_ff;
	assign wr_ctrl  = wr_go && awa_ff[31:2] == CTRL_OFS[31:2] && ws_ff[0];
	assign mem_off  = (awa_ff - MEM_BASE) >> 2;
	assign wr_mem   = wr_go && awa_ff >= MEM_BASE && mem_off < MEM_BYTES && ws_ff[0];
	assign widx     = mem_off[MEM_AW-1:0];
	assign rd_go    = s_arvalid && arr_ff && !rv_ff;
	assign rmem_off = (s_araddr - MEM_BASE) >> 2;

	////////////////////////////////////////////////////////////////////////////
	// Control bits and latch buffer
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_lane = lane_ff;
		nxt_grp  = grp_ff;
		if (wr_ctrl) begin
			nxt_ctrl.lat = ws_ff[0] & wd_ff[LAT_BIT];
			if (!wd_ff[LAT_BIT])
				nxt_ctrl.pgm = 1'b0;
			else if (wd_ff[PGM_BIT] && ctrl_ff.lat && lane_ff != '0)
				nxt_ctrl.pgm = 1'b1;
		end
		if (wr_mem && mode == EPC_LOAD) begin
			if (lane_ff == '0 || grp_ff != widx[MEM_AW-1:3])
				nxt_lane = '0;
			nxt_lane[widx[2:0]] = 1'b1;
			nxt_grp = widx[MEM_AW-1:3];
		end
		if (!nxt_ctrl.lat)
			nxt_lane = '0;
		if (stop_entry) begin
			nxt_ctrl = '0;
			nxt_lane = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= '0;
			lane_ff <= '0;
			grp_ff  <= '0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			lane_ff <= nxt_lane;
			grp_ff  <= nxt_grp;
		end
	end

	// Array contents are not reset; an erased array powers up as zero
	initial begin
		for (int i = 0; i < MEM_BYTES; i++)
			mem_ff[i] = ERASED_VAL;
	end

	// Buffer lanes fill while loading
	generate
		for (genvar g = 0; g < LANES; g++) begin : g_lane
			always_ff @(posedge aclk) begin
				if (wr_mem && mode == EPC_LOAD && widx[2:0] == 3'(g))
					buf_ff[g] <= wd_ff[7:0];
			end
		end
	endgenerate

	// One process owns the array writes, since the index is not constant;
	// bits only ever OR in, so a programmed one cannot return to zero
	always @(posedge aclk) begin
		for (int k = 0; k < LANES; k++) begin
			if (mode == EPC_PROG && lane_ff[k])
				mem_ff[{grp_ff, 3'(k)}] <= mem_ff[{grp_ff, 3'(k)}] | buf_ff[k];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	always_comb begin
		nxt_aw  = aw_ff;
		nxt_awa = awa_ff;
		nxt_w   = w_ff;
		nxt_wd  = wd_ff;
		nxt_ws  = ws_ff;
		nxt_bv  = bv_ff;
		nxt_br  = br_ff;
		if (s_awvalid && !aw_ff) begin
			nxt_aw  = 1'b1;
			nxt_awa = s_awaddr;
		end
		if (s_wvalid && !w_ff) begin
			nxt_w  = 1'b1;
			nxt_wd = s_wdata;
			nxt_ws = s_wstrb;
		end
		if (wr_go) begin
			nxt_aw = 1'b0;
			nxt_w  = 1'b0;
			nxt_bv = 1'b1;
			nxt_br = (awa_ff[31:2] == CTRL_OFS[31:2] || (awa_ff >= MEM_BASE &&
				mem_off < MEM_BYTES)) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bv_ff && s_bready)
			nxt_bv = 1'b0;
		nxt_rv  = rv_ff;
		nxt_rr  = rr_ff;
		nxt_rd  = rd_ff;
		nxt_arr = !rv_ff && !(s_arvalid && arr_ff);
		if (rd_go) begin
			nxt_rv = 1'b1;
			nxt_rr = RESP_OKAY;
			if (s_araddr[31:2] == CTRL_OFS[31:2])
				nxt_rd = {26'h0, ctrl_ff.lat, ctrl_ff.pgm, 4'h0};
			else if (s_araddr[31:2] == STAT_OFS[31:2])
				nxt_rd = {24'h0, lane_ff};
			else if (s_araddr >= MEM_BASE && rmem_off < MEM_BYTES)
				nxt_rd = {24'h0, ctrl_ff.lat ? GARBLE_VAL
					: mem_ff[rmem_off[MEM_AW-1:0]]};
			else begin
				nxt_rd = 32'h0;
				nxt_rr = RESP_SLVERR;
			end
		end
		if (rv_ff && s_rready) begin
			nxt_rv  = 1'b0;
			nxt_arr = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff   <= 1'b0;
			awa_ff  <= '0;
			w_ff    <= 1'b0;
			wd_ff   <= '0;
			ws_ff   <= '0;
			bv_ff   <= 1'b0;
			br_ff   <= '0;
			rv_ff   <= 1'b0;
			rr_ff   <= '0;
			rd_ff   <= '0;
			arr_ff  <= 1'b0;
			stat_ff <= 1'b0;
		end else begin
			aw_ff   <= nxt_aw;
			awa_ff  <= nxt_awa;
			w_ff    <= nxt_w;
			wd_ff   <= nxt_wd;
			ws_ff   <= nxt_ws;
			bv_ff   <= nxt_bv;
			br_ff   <= nxt_br;
			rv_ff   <= nxt_rv;
			rr_ff   <= nxt_rr;
			rd_ff   <= nxt_rd;
			arr_ff  <= nxt_arr;
			stat_ff <= nxt_ctrl.lat;
		end
	end

	assign s_awready      = !aw_ff;
	assign s_wready       = !w_ff;
	assign s_bvalid       = bv_ff;
	assign s_bresp        = br_ff;
	assign s_arready      = arr_ff;
	assign s_rvalid       = rv_ff;
	assign s_rresp        = rr_ff;
	assign s_rdata        = rd_ff;
	assign boot_blocked   = stat_ff;
	assign vector_invalid = stat_ff;
	assign prog_active    = ctrl_ff.pgm;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_pgm_needs_lat;
		@(posedge aclk) disable iff (!aresetn) ctrl_ff.pgm |-> ctrl_ff.lat;
	endproperty
	a_pgm_needs_lat: assert property (p_pgm_needs_lat) else $error("program without latch");
	property p_stop_clears;
		@(posedge aclk) disable iff (!aresetn) stop_entry |=> !ctrl_ff.lat && !ctrl_ff.pgm;
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("stop left latch set");
	property p_pgm_rise;
		@(posedge aclk) disable iff (!aresetn)
			$rose(ctrl_ff.pgm) |-> $past(ctrl_ff.lat) && $past(lane_ff) != 8'h00;
	endproperty
	a_pgm_rise: assert property (p_pgm_rise) else $error("program set too early");
	property p_pgm_hold;
		@(posedge aclk) disable iff (!aresetn)
			$fell(ctrl_ff.pgm) |-> !ctrl_ff.lat;
	endproperty
	a_pgm_hold: assert property (p_pgm_hold) else $error("program cleared alone");
	property p_boot;
		@(posedge aclk) disable iff (!aresetn) boot_blocked == ctrl_ff.lat;
	endproperty
	a_boot: assert property (p_boot) else $error("bootstrap not blocked");
	property p_vec;
		@(posedge aclk) disable iff (!aresetn) vector_invalid == ctrl_ff.lat;
	endproperty
	a_vec: assert property (p_vec) else $error("vector flag wrong");
	property p_garble;
		@(posedge aclk) disable iff (!aresetn)
			rd_go && ctrl_ff.lat && s_araddr >= MEM_BASE && rmem_off < MEM_BYTES
			|=> s_rdata[7:0] == GARBLE_VAL;
	endproperty
	a_garble: assert property (p_garble) else $error("latched read not masked");
	property p_lane;
		@(posedge aclk) disable iff (!aresetn)
			wr_mem && mode == EPC_LOAD && !stop_entry |=> lane_ff[$past(widx[2:0])];
	endproperty
	a_lane: assert property (p_lane) else $error("lane not captured");
	sequence s_prog_req;
		wr_ctrl && !stop_entry && wd_ff[LAT_BIT] && wd_ff[PGM_BIT] && ctrl_ff.lat
			&& lane_ff != 8'h00;
	endsequence
	sequence s_prog_on;
		ctrl_ff.pgm && prog_active;
	endsequence
	property p_prog_start;
		@(posedge aclk) disable iff (!aresetn) s_prog_req |=> s_prog_on;
	endproperty
	a_prog_start: assert property (p_prog_start) else $error("program not started");
endmodule // epc_top

// ---- shared/epc_pkg.sv ----
// Package: register map, field positions and types of the EPROM latch/program control block
package epc_pkg;
	localparam logic [31:0] CTRL_OFS     = 32'h0000001C; // Printed offset 0x0007 is not word aligned
	localparam logic [31:0] CTRL_IDX     = 32'h00000007;
	localparam logic [31:0] STAT_OFS     = 32'h00000020; // Latch status word
	localparam logic [31:0] MEM_BASE     = 32'h00010000; // Array window, one byte per word
	localparam int          MEM_BYTES    = 15168;
	localparam int          VEC_BYTES    = 14;
	localparam int          MEM_AW       = 14;
	localparam int          LAT_BIT      = 5;
	localparam int          PGM_BIT      = 4;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [7:0]  ERASED_VAL   = 8'h00;
	localparam logic [7:0]  GARBLE_VAL   = 8'hFF; // Read value while the latch is open
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam int          LANES        = 8;
	typedef struct packed {
		logic        lat;
		logic        pgm;
	} epc_ctrl_t;
	typedef enum logic [1:0] {
		EPC_READ  = 2'b00,
		EPC_LOAD  = 2'b01,
		EPC_PROG  = 2'b11
	} epc_mode_t;
endpackage

// ---- tb/epc_supply_model.sv ----
// Partner model: external switch that applies the programming supply
`timescale 1ns/1ps
module epc_supply_model (
	input  wire logic aclk,        // Clock
	input  wire logic aresetn,     // Synchronous reset, low
	input  wire logic prog_active, // Program enable from the block
	output logic      supply_on    // Programming supply applied
);
	// Follows program enable a cycle late, never ahead of it
	always_ff @(posedge aclk) begin
		supply_on <= aresetn & prog_active;
	end
endmodule // epc_supply_model

// ---- tb/tb.sv ----
// Testbench: register and array access scenarios for the EPROM control block
`timescale 1ns/1ps
module tb;
	import epc_pkg::*;
	localparam logic [31:0] LAT = 32'h00000001 << LAT_BIT;
	localparam logic [31:0] PGM = 32'h00000001 << PGM_BIT;
	logic        aclk, aresetn, stop_entry, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, boot_blocked, vector_invalid;
	logic        prog_active, supply_on;
	logic [31:0] awaddr, wdata, araddr, rdata, v;
	logic [1:0]  bresp, rresp, r;
	int          err_count, checked;
	epc_top u_dut (.aclk(aclk), .aresetn(aresetn), .stop_entry(stop_entry),
		.s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
		.s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
		.s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready), .boot_blocked(boot_blocked), .vector_invalid(vector_invalid),
		.prog_active(prog_active));
	epc_supply_model u_sup (.aclk(aclk), .aresetn(aresetn), .prog_active(prog_active),
		.supply_on(supply_on));
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [31:0] arr(input int n);
		return MEM_BASE + 32'(4 * n);
	endfunction
	// Each channel is released only at the edge that takes it
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic results;
		if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(CTRL_OFS);
		chk("ctrl", v, 32'(CTRL_RESET));
		rd(arr(0));
		chk("erased", v, 32'(ERASED_VAL));
		rd(arr(MEM_BYTES - 1));
		chk("last resp", 32'(r), 32'(RESP_OKAY));
		rd(arr(MEM_BYTES));
		chk("past resp", 32'(r), 32'(RESP_SLVERR));
		rd(32'h00000040);
		chk("unmapped", 32'(r), 32'(RESP_SLVERR));
		wr(32'h00000040, 32'h00000000);
		chk("wr unmapped", 32'(r), 32'(RESP_SLVERR));
		chk("boot", 32'(boot_blocked), 32'h0);
		chk("vector", 32'(vector_invalid), 32'h0);
	endtask
	task automatic t_guard;
		wr(CTRL_OFS, PGM);
		chk("wr resp", 32'(r), 32'(RESP_OKAY));
		rd(CTRL_OFS);
		chk("pgm only", v, 32'h0);
		wr(CTRL_OFS, LAT);
		wr(CTRL_OFS, LAT | PGM);
		rd(CTRL_OFS);
		chk("no byte", v, LAT);
	endtask
	// Routine runs from the bus side, never fetching from the array
	task automatic t_program;
		repeat (2) @(posedge aclk);
		chk("boot", 32'(boot_blocked), 32'h1);
		chk("vector", 32'(vector_invalid), 32'h1);
		rd(arr(8));
		chk("garbled", v, 32'(GARBLE_VAL));
		wr(arr(16), 32'h33);
		wr(arr(8), 32'h5A);
		wr(arr(9), 32'h0F);
		rd(STAT_OFS);
		chk("lanes", v, 32'h03);
		wr(CTRL_OFS, LAT | PGM);
		repeat (3) @(posedge aclk);
		chk("prog", 32'(prog_active), 32'h1);
		chk("supply", 32'(supply_on), 32'h1);
		wr(CTRL_OFS, LAT);
		rd(CTRL_OFS);
		chk("sw clear", v, LAT | PGM);
		wr(CTRL_OFS, 32'h0);
		rd(CTRL_OFS);
		chk("both clear", v, 32'h0);
		repeat (2) @(posedge aclk);
		chk("prog off", 32'(prog_active), 32'h0);
		chk("supply off", 32'(supply_on), 32'h0);
		rd(arr(8));
		chk("byte8", v, 32'h5A);
		rd(arr(9));
		chk("byte9", v, 32'h0F);
		rd(arr(10));
		chk("byte10", v, 32'h0);
		rd(arr(16));
		chk("dropped", v, 32'h0);
	endtask
	task automatic t_cumul;
		wr(CTRL_OFS, LAT);
		wr(arr(8), 32'hA0);
		wr(CTRL_OFS, LAT | PGM);
		repeat (3) @(posedge aclk);
		wr(CTRL_OFS, 32'h0);
		rd(arr(8));
		chk("or bits", v, 32'hFA);
	endtask
	task automatic t_stop;
		wr(CTRL_OFS, LAT);
		@(posedge aclk);
		stop_entry <= 1'b1;
		@(posedge aclk);
		stop_entry <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("stop boot", 32'(boot_blocked), 32'h0);
		chk("stop vector", 32'(vector_invalid), 32'h0);
		rd(CTRL_OFS);
		chk("stop ctrl", v, 32'h0);
		wr(CTRL_OFS, LAT);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(CTRL_OFS);
		chk("reset ctrl", v, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, stop_entry, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		err_count = 0;
		checked = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset;
		t_guard;
		t_program;
		t_cumul;
		t_stop;
		results;
	end
	// Whole run needs under two hundred cycles; this leaves ample margin
	initial begin
		#500000;
		err_count++;
		results;
	end
endmodule // tb
